// file: event_source_model.sv
// Behavioural timer, pin and comparator event sources
`timescale 1ns/1ps
`default_nettype none

module event_source_model (
    input  wire logic       hclk,
    output var  logic [7:0] timer_zero,
    output var  logic       ext_irq_pin,
    output var  logic [3:0] upper_port_pins,
    output var  logic [1:0] cmp_out
);

    // ****************************************************
    // Idle levels
    // ****************************************************
    initial begin
        timer_zero      = 8'h00;
        ext_irq_pin     = 1'b0;
        upper_port_pins = 4'h0;
        cmp_out         = 2'h0;
    end

    // ****************************************************
    // Event stimulus: 0 timer, 1 ext rise, 2 port, 3 cmp
    // ****************************************************
    task automatic fire(input int k);
        @(posedge hclk);
        case (k)
            0: begin
                timer_zero <= 8'hFF;
                @(posedge hclk);
                timer_zero <= 8'h00;
            end
            1: ext_irq_pin <= 1'b1;
            2: upper_port_pins <= upper_port_pins ^ 4'h1;
            default: cmp_out <= cmp_out ^ 2'h2;
        endcase
    endtask

    // Falling edge on the external pin
    task automatic ext_low();
        @(posedge hclk);
        ext_irq_pin <= 1'b0;
    endtask

endmodule

`default_nettype wire

// file: interrupt_enable_flag_logic.sv
// Interrupt enable and flag logic with AHB-Lite register slave
//
// Summary of operation
// RULE_01: Every flag sets on its event whatever its enable or the master enable.
// RULE_02: The master enable at bit 7 passes unmasked requests to core_irq_req and blocks them all when clear, but does not gate irq.
// RULE_03: The control register holds all enables and flags but the comparator's; the event status and event mask bits for irq sit in their own registers.
// RULE_04: The control register answers identically at two indexes.
// RULE_05: The external enable at bit 4 passes or masks the external request.
// RULE_06: The port-change flag at bit 0 sets on any upper port pin change until cleared.
// RULE_07: The comparator enable register has one writable enable at bit 6.
// RULE_08: The comparator flag at bit 6 sets on a comparator change and is writable.
// RULE_09: Other bits of both comparator registers read zero and ignore writes.
// RULE_10: Software should clear a pending flag before setting its enable.
// RULE_11: The core request is the master enable and any enabled pending source.
// RULE_12: The timer flag sets on wrap to zero, the external flag on the chosen edge.
`timescale 1ns/1ps
`default_nettype none

module interrupt_enable_flag_logic (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp,
    input  wire logic [7:0]  timer_zero,
    input  wire logic        ext_irq_pin,
    input  wire logic [3:0]  upper_port_pins,
    input  wire logic [1:0]  cmp_out,
    output logic             core_irq_req,
    output logic             irq
);

    // ****************************************************
    // Bus slave
    // ****************************************************
    irq_flag_pkg::bus_phase_t dp_reg;
    logic                     rd_wait_reg;
    logic [31:0]              hrdata_reg;
    logic                     accept;
    logic                     wr_en;
    logic [7:0]               wdata;
    logic [7:0]               rd_mux;

    assign accept = hsel && htrans[1] && hready;
    assign wr_en = dp_reg.valid && dp_reg.write && hready
                   && dp_reg.in_range;
    assign wdata = hwdata[7:0];
    assign hreadyout = !(dp_reg.valid && rd_wait_reg);
    assign hresp = irq_flag_pkg::HRESP_OKAY;
    assign hrdata = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_reg      <= '0;
            rd_wait_reg <= 1'b0;
        end else if (accept) begin
            dp_reg.valid    <= 1'b1;
            dp_reg.write    <= hwrite;
            dp_reg.in_range <= ~|haddr[31:irq_flag_pkg::HIGH_LSB];
            dp_reg.idx      <= haddr[irq_flag_pkg::IDX_MSB:
                                     irq_flag_pkg::IDX_LSB];
            rd_wait_reg     <= !hwrite;
        end else begin
            if (hready) begin
                dp_reg.valid <= 1'b0;
            end
            rd_wait_reg <= 1'b0;
        end
    end

    // Read data loaded in the wait cycle of each read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (dp_reg.valid && rd_wait_reg) begin
            hrdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    // ****************************************************
    // Input synchronisers and event detection
    // ****************************************************
    logic       ext_s1_reg;
    logic       ext_s2_reg;
    logic       ext_prev_reg;
    logic [3:0] port_s1_reg;
    logic [3:0] port_s2_reg;
    logic [3:0] port_prev_reg;
    logic [7:0] timer_prev_reg;
    logic [1:0] cmp_prev_reg;
    logic       edge_rising_reg;
    irq_flag_pkg::irq_events_t ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1_reg   <= 1'b0;
            ext_s2_reg   <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_s1_reg   <= ext_irq_pin;
            ext_s2_reg   <= ext_s1_reg;
            ext_prev_reg <= ext_s2_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_s1_reg   <= 4'h0;
            port_s2_reg   <= 4'h0;
            port_prev_reg <= 4'h0;
        end else begin
            port_s1_reg   <= upper_port_pins;
            port_s2_reg   <= port_s1_reg;
            port_prev_reg <= port_s2_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_prev_reg <= irq_flag_pkg::TIMER_BOTTOM;
            cmp_prev_reg   <= 2'h0;
        end else begin
            timer_prev_reg <= timer_zero;
            cmp_prev_reg   <= cmp_out;
        end
    end

    always_comb begin
        ev.timer = (timer_prev_reg == irq_flag_pkg::TIMER_TOP)
                   && (timer_zero == irq_flag_pkg::TIMER_BOTTOM); // RULE_12
        ev.ext   = edge_rising_reg ? (ext_s2_reg && !ext_prev_reg)
                                   : (!ext_s2_reg && ext_prev_reg); // RULE_12
        ev.port  = |(port_s2_reg ^ port_prev_reg); // RULE_06
        ev.cmp   = |(cmp_out ^ cmp_prev_reg); // RULE_08
    end

    // ****************************************************
    // Register file
    // ****************************************************
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic       cmp_flag_reg;
    logic       cmp_flag_next;
    logic       cmp_en_reg;
    logic [3:0] evt_status_reg;
    logic [3:0] evt_status_next;
    logic [3:0] evt_mask_reg;
    logic       wr_ctrl;

    assign wr_ctrl = wr_en
        && (dp_reg.idx == irq_flag_pkg::IDX_CTRL_STATUS_A
            || dp_reg.idx == irq_flag_pkg::IDX_CTRL_STATUS_B); // RULE_04

    // Flag set wins over a clearing write
    always_comb begin
        ctrl_next = wr_ctrl ? wdata : ctrl_reg; // RULE_03
        ctrl_next[irq_flag_pkg::TIMER_FLAG_BIT] =
            ctrl_next[irq_flag_pkg::TIMER_FLAG_BIT] | ev.timer; // RULE_01
        ctrl_next[irq_flag_pkg::EXT_FLAG_BIT] =
            ctrl_next[irq_flag_pkg::EXT_FLAG_BIT] | ev.ext; // RULE_01
        ctrl_next[irq_flag_pkg::PORT_FLAG_BIT] =
            ctrl_next[irq_flag_pkg::PORT_FLAG_BIT] | ev.port; // RULE_06
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= irq_flag_pkg::CTRL_STATUS_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_comb begin
        cmp_flag_next = cmp_flag_reg;
        if (wr_en && dp_reg.idx == irq_flag_pkg::IDX_PERIPH_FLAGS) begin
            cmp_flag_next = wdata[irq_flag_pkg::CMP_BIT]; // RULE_09
        end
        cmp_flag_next = cmp_flag_next | ev.cmp; // RULE_08
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_flag_reg <= 1'b0;
        end else begin
            cmp_flag_reg <= cmp_flag_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_en_reg <= 1'b0;
        end else if (wr_en
                     && dp_reg.idx == irq_flag_pkg::IDX_PERIPH_ENABLES) begin
            cmp_en_reg <= wdata[irq_flag_pkg::CMP_BIT]; // RULE_07
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_rising_reg <= irq_flag_pkg::EDGE_RESET;
            evt_mask_reg    <= irq_flag_pkg::EVENT_RESET;
        end else if (wr_en) begin
            if (dp_reg.idx == irq_flag_pkg::IDX_EDGE_CONFIG) begin
                edge_rising_reg <= wdata[irq_flag_pkg::EDGE_RISING_BIT];
            end
            if (dp_reg.idx == irq_flag_pkg::IDX_EVENT_MASK) begin
                evt_mask_reg <= wdata[3:0];
            end
        end
    end

    // Sticky event status, write one to clear, set wins
    always_comb begin
        evt_status_next = evt_status_reg;
        if (wr_en && dp_reg.idx == irq_flag_pkg::IDX_EVENT_STATUS) begin
            evt_status_next = evt_status_reg & ~wdata[3:0];
        end
        evt_status_next = evt_status_next | ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_status_reg <= irq_flag_pkg::EVENT_RESET;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (dp_reg.in_range) begin
            case (dp_reg.idx)
                irq_flag_pkg::IDX_CTRL_STATUS_A,
                irq_flag_pkg::IDX_CTRL_STATUS_B: begin
                    rd_mux = ctrl_reg; // RULE_04
                end
                irq_flag_pkg::IDX_PERIPH_FLAGS: begin
                    rd_mux[irq_flag_pkg::CMP_BIT] = cmp_flag_reg; // RULE_09
                end
                irq_flag_pkg::IDX_PERIPH_ENABLES: begin
                    rd_mux[irq_flag_pkg::CMP_BIT] = cmp_en_reg; // RULE_09
                end
                irq_flag_pkg::IDX_EVENT_STATUS: begin
                    rd_mux = {4'h0, evt_status_reg};
                end
                irq_flag_pkg::IDX_EVENT_MASK: begin
                    rd_mux = {4'h0, evt_mask_reg};
                end
                irq_flag_pkg::IDX_EDGE_CONFIG: begin
                    rd_mux = {7'h00, edge_rising_reg};
                end
                default: begin
                    rd_mux = 8'h00;
                end
            endcase
        end
    end

    // ****************************************************
    // Request outputs
    // ****************************************************
    logic any_src;
    always_comb begin
        any_src =
            (ctrl_reg[irq_flag_pkg::TIMER_EN_BIT]
             && ctrl_reg[irq_flag_pkg::TIMER_FLAG_BIT])
            || (ctrl_reg[irq_flag_pkg::EXT_EN_BIT]
                && ctrl_reg[irq_flag_pkg::EXT_FLAG_BIT]) // RULE_05
            || (ctrl_reg[irq_flag_pkg::PORT_EN_BIT]
                && ctrl_reg[irq_flag_pkg::PORT_FLAG_BIT])
            || (ctrl_reg[irq_flag_pkg::PERIPH_EN_BIT]
                && cmp_en_reg && cmp_flag_reg); // RULE_11
    end

    assign core_irq_req = ctrl_reg[irq_flag_pkg::GLOBAL_EN_BIT]
                          && any_src; // RULE_02
    assign irq = |(evt_status_reg & evt_mask_reg);

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_flag_any_enable;
        ev.timer |=> ctrl_reg[irq_flag_pkg::TIMER_FLAG_BIT];
    endproperty
    a_flag_any_enable: assert property (p_flag_any_enable) // RULE_01
        else $error("timer flag not set by its event");
    property p_master_blocks;
        !ctrl_reg[irq_flag_pkg::GLOBAL_EN_BIT] |-> !core_irq_req;
    endproperty
    a_master_blocks: assert property (p_master_blocks) // RULE_02
        else $error("request while master enable clear");
    property p_alias_read;
        (dp_reg.valid && rd_wait_reg && dp_reg.in_range
         && dp_reg.idx == irq_flag_pkg::IDX_CTRL_STATUS_B)
        |=> hrdata[7:0] == $past(ctrl_reg) && hreadyout;
    endproperty
    a_alias_read: assert property (p_alias_read) // RULE_04
        else $error("second index does not read control register");
    property p_ext_masked;
        !ctrl_reg[irq_flag_pkg::EXT_EN_BIT]
        && !ctrl_reg[irq_flag_pkg::TIMER_FLAG_BIT]
        && !ctrl_reg[irq_flag_pkg::PORT_FLAG_BIT] && !cmp_flag_reg
        |-> !core_irq_req;
    endproperty
    a_ext_masked: assert property (p_ext_masked) // RULE_05
        else $error("masked external request reached core");
    property p_port_change;
        $changed(port_s2_reg) |-> ##1 ctrl_reg[0];
    endproperty
    a_port_change: assert property (p_port_change) // RULE_06
        else $error("port change flag missed");
    property p_cmp_enable_write;
        wr_en && dp_reg.idx == irq_flag_pkg::IDX_PERIPH_ENABLES
        |=> cmp_en_reg == $past(hwdata[6]);
    endproperty
    a_cmp_enable_write: assert property (p_cmp_enable_write) // RULE_07
        else $error("comparator enable write lost");
    property p_cmp_flag;
        $changed(cmp_out) |=> cmp_flag_reg [*1];
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) // RULE_08
        else $error("comparator flag missed");
    property p_unimpl_zero;
        (dp_reg.valid && rd_wait_reg && dp_reg.in_range
         && (dp_reg.idx == irq_flag_pkg::IDX_PERIPH_FLAGS
             || dp_reg.idx == irq_flag_pkg::IDX_PERIPH_ENABLES))
        |=> hrdata[7] == 1'b0 && hrdata[5:0] == 6'h00;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) // RULE_09
        else $error("unimplemented comparator bits not zero");
    property p_periph_path;
        ctrl_reg[7] && ctrl_reg[6] && cmp_en_reg && cmp_flag_reg
        |-> core_irq_req;
    endproperty
    a_periph_path: assert property (p_periph_path) // RULE_11
        else $error("comparator request not raised");
    property p_wrap_sets;
        timer_prev_reg == 8'hFF && timer_zero == 8'h00
        |=> ctrl_reg[2] ##1 (ctrl_reg[2] || $past(wr_ctrl));
    endproperty
    a_wrap_sets: assert property (p_wrap_sets) // RULE_12
        else $error("timer wrap did not set flag");
    property p_read_wait;
        accept && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait)
        else $error("read wait state wrong");
    c_core_req: cover property (!core_irq_req ##1 core_irq_req);
    c_irq_out: cover property (irq);
    c_alias_write: cover property (wr_ctrl
        && dp_reg.idx == irq_flag_pkg::IDX_CTRL_STATUS_B);
    c_set_vs_clear: cover property (wr_ctrl && ev.port);

endmodule

`default_nettype wire

// file: irq_flag_pkg.sv
// Constants and carrier types for the interrupt enable and flag block
package irq_flag_pkg;

    // ****************************************************
    // Register indexes (byte address is four times index)
    // ****************************************************
    localparam logic [7:0] IDX_CTRL_STATUS_A = 8'h0B;
    localparam logic [7:0] IDX_CTRL_STATUS_B = 8'h8B;
    localparam logic [7:0] IDX_PERIPH_FLAGS  = 8'h0C;
    localparam logic [7:0] IDX_PERIPH_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_EVENT_STATUS  = 8'h40;
    localparam logic [7:0] IDX_EVENT_MASK    = 8'h41;
    localparam logic [7:0] IDX_EDGE_CONFIG   = 8'h42;

    // ****************************************************
    // Bus decode fields
    // ****************************************************
    localparam int IDX_LSB  = 2;
    localparam int IDX_MSB  = 9;
    localparam int HIGH_LSB = 10;

    // ****************************************************
    // Field positions of the control/status register
    // ****************************************************
    localparam int GLOBAL_EN_BIT  = 7;
    localparam int PERIPH_EN_BIT  = 6;
    localparam int TIMER_EN_BIT   = 5;
    localparam int EXT_EN_BIT     = 4;
    localparam int PORT_EN_BIT    = 3;
    localparam int TIMER_FLAG_BIT = 2;
    localparam int EXT_FLAG_BIT   = 1;
    localparam int PORT_FLAG_BIT  = 0;

    // Comparator bit in both peripheral registers
    localparam int CMP_BIT = 6;

    // Edge configuration: 1 selects rising edge
    localparam int EDGE_RISING_BIT = 0;

    // ****************************************************
    // Reset values and fixed values
    // ****************************************************
    localparam logic [7:0]  CTRL_STATUS_RESET = 8'h00;
    localparam logic [3:0]  EVENT_RESET       = 4'h0;
    localparam logic        EDGE_RESET        = 1'b1;
    localparam logic [7:0]  TIMER_TOP         = 8'hFF;
    localparam logic [7:0]  TIMER_BOTTOM      = 8'h00;
    localparam logic [1:0]  HRESP_OKAY        = 2'h0;

    // ****************************************************
    // Carrier types
    // ****************************************************
    typedef struct packed {
        logic cmp;
        logic port;
        logic ext;
        logic timer;
    } irq_events_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       in_range;
        logic [7:0] idx;
    } bus_phase_t;

endpackage

// file: tb_interrupt_enable_flag_logic.sv
// Self-checking testbench for the interrupt enable and flag block
`timescale 1ns/1ps
`default_nettype none

module tb_interrupt_enable_flag_logic;

    localparam logic [7:0] CA = irq_flag_pkg::IDX_CTRL_STATUS_A;
    localparam logic [7:0] CB = irq_flag_pkg::IDX_CTRL_STATUS_B;
    localparam logic [7:0] PF = irq_flag_pkg::IDX_PERIPH_FLAGS;
    localparam logic [7:0] PE = irq_flag_pkg::IDX_PERIPH_ENABLES;
    localparam logic [7:0] ES = irq_flag_pkg::IDX_EVENT_STATUS;
    localparam logic [7:0] EM = irq_flag_pkg::IDX_EVENT_MASK;
    localparam logic [7:0] EC = irq_flag_pkg::IDX_EDGE_CONFIG;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [1:0]  hresp;
    logic [7:0]  timer_zero;
    logic        ext_irq_pin;
    logic [3:0]  upper_port_pins;
    logic [1:0]  cmp_out;
    logic        core_irq_req;
    logic        irq;
    int          fails;
    int          checked;

    interrupt_enable_flag_logic interrupt_enable_flag_logic_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .timer_zero(timer_zero), .ext_irq_pin(ext_irq_pin),
        .upper_port_pins(upper_port_pins), .cmp_out(cmp_out),
        .core_irq_req(core_irq_req), .irq(irq)
    );

    event_source_model event_source_model_i (
        .hclk(hclk), .timer_zero(timer_zero), .ext_irq_pin(ext_irq_pin),
        .upper_port_pins(upper_port_pins), .cmp_out(cmp_out)
    );

    always #2.5 hclk = ~hclk;

    // ****************************************************
    // Bus and compare helpers
    // ****************************************************
    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%08h exp=%08h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic [31:0] addr, input logic wr,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= addr;
        hwrite <= wr;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        rd = hrdata;
        if (n >= 64) begin
            fails++;
            $display("[ERR] t=%0t got=%08h exp=%08h", $time, n, 64);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        xfer(ba(idx), 1'b1, {24'h0, d}, r);
    endtask

    task automatic rd_chk(input logic [31:0] addr, input logic [7:0] exp);
        logic [31:0] r;
        xfer(addr, 1'b0, 32'h0, r);
        chk(r, {24'h0, exp});
    endtask

    task automatic req_chk(input logic exp_req, input logic exp_irq);
        @(negedge hclk);
        chk({30'h0, core_irq_req, irq}, {30'h0, exp_req, exp_irq});
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_reset();
        rd_chk(ba(CA), 8'h00);
        rd_chk(ba(PF), 8'h00);
        rd_chk(ba(PE), 8'h00);
        rd_chk(ba(ES), 8'h00);
        rd_chk(ba(EC), 8'h01);
        req_chk(1'b0, 1'b0);
        chk({30'h0, hresp}, 32'h0);
    endtask

    task automatic t_alias();
        wr(CA, 8'h68);
        rd_chk(ba(CB), 8'h68);
        wr(CB, 8'h18);
        rd_chk(ba(CA), 8'h18);
        wr(CA, 8'h00);
    endtask

    task automatic t_cmp_regs();
        wr(PE, 8'hFF);
        rd_chk(ba(PE), 8'h40);
        wr(PF, 8'hBF);
        rd_chk(ba(PF), 8'h00);
        wr(PF, 8'hFF);
        rd_chk(ba(PF), 8'h40);
        wr(PF, 8'h00);
        wr(PE, 8'h00);
        rd_chk(ba(PF), 8'h00);
    endtask

    task automatic t_flags();
        for (int k = 0; k < 4; k++) begin
            event_source_model_i.fire(k);
        end
        repeat (6) @(posedge hclk);
        rd_chk(ba(CA), 8'h07);
        rd_chk(ba(PF), 8'h40);
        rd_chk(ba(ES), 8'h0F);
        req_chk(1'b0, 1'b0);
        wr(EM, 8'h08);
        req_chk(1'b0, 1'b1);
        wr(ES, 8'h08);
        rd_chk(ba(ES), 8'h07);
        req_chk(1'b0, 1'b0);
        wr(ES, 8'h07);
        wr(EM, 8'h00);
        rd_chk(ba(ES), 8'h00);
        rd_chk(ba(CA), 8'h07);
        wr(CA, 8'h00);
        wr(PF, 8'h00);
        event_source_model_i.ext_low();
        repeat (6) @(posedge hclk);
        rd_chk(ba(CA), 8'h00);
        wr(EC, 8'h00);
        rd_chk(ba(EC), 8'h00);
        event_source_model_i.fire(1);
        repeat (6) @(posedge hclk);
        rd_chk(ba(CA), 8'h00);
        event_source_model_i.ext_low();
        repeat (6) @(posedge hclk);
        rd_chk(ba(CA), 8'h02);
        wr(EC, 8'h01);
        wr(CA, 8'h00);
    endtask

    task automatic t_req();
        logic [7:0] en_m [4] = '{8'h20, 8'h10, 8'h08, 8'h40};
        logic [7:0] fl_m [4] = '{8'h04, 8'h02, 8'h01, 8'h00};
        for (int k = 0; k < 4; k++) begin
            wr(CA, 8'h00);
            wr(PF, 8'h00);
            wr(PE, 8'h40);
            wr(CA, 8'h80 | en_m[k]);
            req_chk(1'b0, 1'b0);
            event_source_model_i.fire(k);
            repeat (6) @(posedge hclk);
            req_chk(1'b1, 1'b0);
            wr(CA, 8'h80 | fl_m[k]);
            req_chk(1'b0, 1'b0);
            wr(CA, en_m[k] | fl_m[k]);
            req_chk(1'b0, 1'b0);
        end
        wr(CA, 8'hC0);
        wr(PF, 8'h40);
        req_chk(1'b1, 1'b0);
        wr(PE, 8'h00);
        req_chk(1'b0, 1'b0);
        wr(CA, 8'h00);
        wr(PF, 8'h00);
    endtask

    task automatic t_unmapped();
        logic [31:0] r;
        wr(CA, 8'h68);
        rd_chk(32'h0000042C, 8'h00);
        xfer(32'h0000042C, 1'b1, 32'h000000FF, r);
        wr(8'h80, 8'hFF);
        rd_chk(ba(8'h80), 8'h00);
        rd_chk(ba(CA), 8'h68);
        wr(CA, 8'h00);
    endtask

    // ****************************************************
    // Sequence, watchdog and verdict
    // ****************************************************
    task automatic stop_test();
        $display("Checks made: %0d, mismatches: %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        hclk    = 1'b0;
        hresetn = 1'b0;
        hsel    = 1'b0;
        haddr   = 32'h0;
        htrans  = 2'h0;
        hwrite  = 1'b0;
        hsize   = 3'h2;
        hwdata  = 32'h0;
        fails   = 0;
        checked = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_alias();
        t_cmp_regs();
        t_flags();
        t_req();
        t_unmapped();
        stop_test();
    end

    initial begin
        #20000;
        fails++;
        stop_test();
    end

endmodule

`default_nettype wire
